// >>> design/bpgs_seq.sv
// Supervisory sequencer: start-up, protection, discharge and output-ok control
`timescale 1ns/10ps
`default_nettype none
module bpgs_seq
    import bpgs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Comparator flags from the analog side
    input wire logic turn_on_in,
    input wire logic supply_lockout_in,
    input wire logic vcc_lockout_in,
    input wire logic fb_in_window_in,
    input wire logic fb_out_window_in,
    input wire logic overvoltage_guard_in,
    input wire logic undervoltage_guard_in,
    input wire logic overcurrent_valley_in,
    input wire logic overcurrent_peak_in,
    input wire logic overtemp_in,
    input wire logic ramp_cap_low_in,
    input wire logic ref_above_fb_in,
    input wire logic ramp_done_in,
    input wire logic zero_current_in,
    input wire logic high_duty_in,
    // Controls to the power stage and the output-ok pin
    output logic ramp_charge,
    output logic ramp_discharge,
    output logic switch_enable,
    output logic high_side_block,
    output logic low_side_block,
    output logic rectifier_off,
    output logic freq_reduce,
    output logic discharge_on,
    output logic output_ok_flag_o,
    output logic output_ok_flag_oe
);
    localparam int unsigned NS = 15;

    logic [NS-1:0] raw;
    logic [NS-1:0] syn;
    bpgs_state_t state_q, state_d;
    logic [TW-1:0] hic_q, hic_d;
    logic [1:0] ctrl_q;
    logic [TW-1:0] sslen_q;
    logic ok_q, ok_d;
    logic [31:0] prdata_d;

    // Power stage is live only in the ramp and run states
    function automatic logic stage_live(input bpgs_state_t s);
        return (s == BPGS_SS_RAMP) || (s == BPGS_RUN);
    endfunction : stage_live

    // All pin-level comparator flags pass two flops
    assign raw = {high_duty_in, zero_current_in, ramp_done_in, ref_above_fb_in,
                  ramp_cap_low_in, overtemp_in, overcurrent_peak_in, overcurrent_valley_in,
                  undervoltage_guard_in, overvoltage_guard_in, fb_out_window_in,
                  fb_in_window_in, vcc_lockout_in, supply_lockout_in, turn_on_in};
    bpgs_sync #(.W(NS)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .din(raw),
        .dout(syn)
    );

    wire logic turn_on = syn[0];
    wire logic sup_lock = syn[1];
    wire logic vcc_lock = syn[2];
    wire logic fb_in_win = syn[3];
    wire logic fb_out_win = syn[4];
    wire logic ov_flag = syn[5];
    wire logic uv_flag = syn[6];
    wire logic oc_valley = syn[7];
    wire logic oc_peak = syn[8];
    wire logic hot = syn[9];
    wire logic cap_low = syn[10];
    wire logic ref_above = syn[11];
    wire logic ramp_done = syn[12];
    wire logic zero_cur = syn[13];
    wire logic high_duty = syn[14];

    // Global enable: turn-on, supply and regulator lockouts, thermal, software
    wire logic turn_off_cond = !turn_on;
    wire logic lock_cond = sup_lock || vcc_lock;
    wire logic go = !turn_off_cond && !lock_cond && !hot && ctrl_q[CTRL_SWEN_BIT];
    wire logic switching = stage_live(state_q);
    // Registered stage controls follow the next state, one decode shared
    wire logic live_d = stage_live(state_d);

    // Deglitch timers
    logic ov_done, uv_done, ok_rise_done, ok_fall_done;
    bpgs_deglitch u_ov (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .cond(ov_flag && switching),
        .limit(TW'(OV_DEG_CYC)),
        .done(ov_done)
    );
    bpgs_deglitch u_uv (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .cond(uv_flag && state_q == BPGS_RUN),
        .limit(TW'(UV_WAIT_CYC)),
        .done(uv_done)
    );
    bpgs_deglitch u_okr (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .cond(fb_in_win && state_q == BPGS_RUN),
        .limit(TW'(OK_RISE_CYC)),
        .done(ok_rise_done)
    );
    bpgs_deglitch u_okf (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .cond(fb_out_win),
        .limit(TW'(OK_FALL_CYC)),
        .done(ok_fall_done)
    );

    // Hiccup length: 10.5 soft-start durations
    wire logic [TW+7:0] hic_prod = sslen_q * (TW+8)'(HICCUP_TENTHS);
    wire logic [TW-1:0] hic_len = TW'(hic_prod / (TW+8)'(10));

    // Next-state logic
    always_comb begin
        state_d = state_q;
        hic_d = hic_q;
        if (!go) begin
            state_d = BPGS_OFF;
        end else begin
            unique case (state_q)
                BPGS_OFF: begin
                    state_d = cap_low ? BPGS_SS_WAIT : BPGS_SS_DIS;
                end
                BPGS_SS_DIS: begin
                    if (cap_low) begin
                        state_d = BPGS_SS_WAIT;
                    end
                end
                BPGS_SS_WAIT: begin
                    if (ref_above) begin
                        state_d = BPGS_SS_RAMP;
                    end
                end
                BPGS_SS_RAMP: begin
                    if (ov_done) begin
                        state_d = BPGS_OV;
                    end else if (ramp_done) begin
                        state_d = BPGS_RUN;
                    end
                end
                BPGS_RUN: begin
                    if (ov_done) begin
                        state_d = BPGS_OV;
                    end else if (uv_done) begin
                        state_d = BPGS_HICCUP;
                        hic_d = '0;
                    end
                end
                BPGS_OV: begin
                    if (!ov_flag) begin
                        state_d = BPGS_RUN;
                    end
                end
                BPGS_HICCUP: begin
                    if (hic_q >= hic_len) begin
                        state_d = BPGS_SS_DIS;
                    end else begin
                        hic_d = hic_q + 1'b1;
                    end
                end
            endcase
        end
    end

    // State and hiccup timer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= BPGS_OFF;
            hic_q <= '0;
        end else if (ce) begin
            state_q <= state_d;
            hic_q <= hic_d;
        end
    end

    // Output-ok: released after in-window deglitch, pulled low on faults
    always_comb begin
        ok_d = ok_q;
        if (!go || ok_fall_done || state_q != BPGS_RUN) begin
            ok_d = 1'b0;
        end else if (ok_rise_done) begin
            ok_d = 1'b1;
        end
    end

    // Power-stage controls, registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ok_q <= 1'b0;
            ramp_charge <= 1'b0;
            ramp_discharge <= 1'b0;
            switch_enable <= 1'b0;
            high_side_block <= 1'b1;
            low_side_block <= 1'b1;
            rectifier_off <= 1'b0;
            freq_reduce <= 1'b0;
            discharge_on <= 1'b0;
        end else if (ce) begin
            ok_q <= ok_d;
            ramp_charge <= (state_d == BPGS_SS_WAIT) || (state_d == BPGS_SS_RAMP)
                || (state_d == BPGS_RUN);
            ramp_discharge <= (state_d == BPGS_SS_DIS) || (state_d == BPGS_HICCUP);
            switch_enable <= live_d;
            // Cycle-by-cycle limits block the offending switch
            high_side_block <= !live_d || oc_peak;
            low_side_block <= !live_d || oc_valley;
            // Rectifier stays on at zero current only in the forced variant
            rectifier_off <= !ctrl_q[CTRL_FORCED_BIT] && zero_cur;
            freq_reduce <= high_duty;
            discharge_on <= (state_d == BPGS_OFF && (turn_off_cond || hot))
                || state_d == BPGS_OV || state_d == BPGS_HICCUP;
        end
    end

    // Open-drain pin: enabled (pulling low) unless output is ok
    assign output_ok_flag_o = 1'b0;
    assign output_ok_flag_oe = !ok_q;

    // APB decode
    wire logic sel_ctrl = (paddr == CTRL_OFS);
    wire logic sel_stat = (paddr == STAT_OFS);
    wire logic sel_sslen = (paddr == SSLEN_OFS);
    wire logic hit = sel_ctrl || sel_stat || sel_sslen;
    wire logic acc = psel && penable;
    wire logic wr = acc && pwrite && ce;
    assign pready = 1'b1;
    assign pslverr = acc && !hit;

    // Read mux
    always_comb begin
        prdata_d = 32'h0000_0000;
        if (sel_ctrl) begin
            prdata_d = {30'h0, ctrl_q};
        end else if (sel_stat) begin
            prdata_d = {20'h0_0000, ok_q, discharge_on, switch_enable, hot, ov_flag, uv_flag,
                        lock_cond, turn_on, 1'b0, state_q};
        end else if (sel_sslen) begin
            prdata_d = {8'h00, sslen_q};
        end
    end

    // Register writes and registered read data
    // Clock enable low freezes the registers and the read data alike
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST;
            sslen_q <= TW'(SS_CYC_DEF);
            prdata <= 32'h0000_0000;
        end else if (ce) begin
            if (wr && sel_ctrl) begin
                ctrl_q <= pwdata[1:0];
            end
            if (wr && sel_sslen) begin
                sslen_q <= pwdata[TW-1:0];
            end
            if (psel && !penable && !pwrite) begin
                prdata <= prdata_d;
            end
        end
    end
endmodule : bpgs_seq
`default_nettype wire

// >>> common/bpgs_pkg.sv
// Package of constants and types for the buck protection and output-ok sequencer
package bpgs_pkg;
    // Clock rate in kHz, 40 MHz
    localparam int unsigned CLK_KHZ = 40000;
    // Deglitch and wait times in microseconds, as printed
    localparam int unsigned OV_DEG_US = 32;
    localparam int unsigned UV_WAIT_US = 256;
    localparam int unsigned OK_RISE_US = 64;
    localparam int unsigned OK_FALL_US = 32;
    // Cycle counts derived from the times
    localparam int unsigned OV_DEG_CYC = OV_DEG_US * CLK_KHZ / 1000;
    localparam int unsigned UV_WAIT_CYC = UV_WAIT_US * CLK_KHZ / 1000;
    localparam int unsigned OK_RISE_CYC = OK_RISE_US * CLK_KHZ / 1000;
    localparam int unsigned OK_FALL_CYC = OK_FALL_US * CLK_KHZ / 1000;
    // Hiccup length in tenths of a soft-start duration (10.5)
    localparam int unsigned HICCUP_TENTHS = 105;
    // Default soft-start duration in cycles, arbitrary default
    localparam int unsigned SS_CYC_DEF = 88000;
    // Timer width
    localparam int unsigned TW = 24;
    // APB register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] SSLEN_OFS = 8'h08;
    // Control field positions
    localparam int unsigned CTRL_FORCED_BIT = 0;
    localparam int unsigned CTRL_SWEN_BIT = 1;
    localparam logic [1:0] CTRL_RST = 2'h2;
    // Sequencer states
    typedef enum logic [2:0] {
        BPGS_OFF, BPGS_SS_DIS, BPGS_SS_WAIT, BPGS_SS_RAMP, BPGS_RUN, BPGS_OV, BPGS_HICCUP
    } bpgs_state_t;
endpackage : bpgs_pkg

// >>> design/bpgs_sync.sv
// Two-flop synchroniser bank for comparator inputs
`timescale 1ns/10ps
`default_nettype none
module bpgs_sync #(
    parameter int unsigned W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;
    // First stage is read only by the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            dout <= '0;
        end else if (ce) begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule : bpgs_sync
`default_nettype wire

// >>> design/bpgs_deglitch.sv
// Qualifying-condition counter that restarts when its condition drops
`timescale 1ns/10ps
`default_nettype none
module bpgs_deglitch
    import bpgs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic cond,
    input wire logic [TW-1:0] limit,
    output logic done
);
    logic [TW-1:0] cnt_q;
    wire logic expired = (cnt_q >= limit);
    // Count while condition holds, restart on drop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            done <= 1'b0;
        end else if (ce) begin
            if (!cond) begin
                cnt_q <= '0;
                done <= 1'b0;
            end else if (!expired) begin
                cnt_q <= cnt_q + 1'b1;
            end else begin
                done <= 1'b1;
            end
        end
    end
endmodule : bpgs_deglitch
`default_nettype wire

// >>> dv/bpgs_host_model.sv
// Model of the system sequencer on the output-ok and turn-on lines
`timescale 1ns/10ps
`default_nettype none
module bpgs_host_model (
    input wire logic output_ok_flag_o,
    input wire logic output_ok_flag_oe,
    input wire logic hold_off,
    output logic ok_seen,
    output logic turn_on_line
);
    // Pull-up lifts the output-ok pin whenever the device lets go
    assign ok_seen = output_ok_flag_oe ? output_ok_flag_o : 1'b1;
    // Open-drain turn-on drive; a released line floats high
    assign turn_on_line = !hold_off;
endmodule : bpgs_host_model
`default_nettype wire

// >>> dv/bpgs_seq_assertions.sv
// Port checker of the supervisory sequencer
`timescale 1ns/10ps
`default_nettype none
module bpgs_seq_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic turn_on_in,
    input wire logic supply_lockout_in,
    input wire logic fb_in_window_in,
    input wire logic fb_out_window_in,
    input wire logic overvoltage_guard_in,
    input wire logic undervoltage_guard_in,
    input wire logic overtemp_in,
    input wire logic ramp_cap_low_in,
    input wire logic ramp_charge,
    input wire logic switch_enable,
    input wire logic high_side_block,
    input wire logic low_side_block,
    input wire logic discharge_on,
    input wire logic output_ok_flag_oe
);
    logic [15:0] ov_q, uv_q, out_q, win_q;
    // Saturating run lengths of the comparator levels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {ov_q, uv_q, out_q, win_q} <= '0;
        end else begin
            ov_q <= overvoltage_guard_in ? ov_q + 16'(~&ov_q) : 16'h0;
            uv_q <= undervoltage_guard_in ? uv_q + 16'(~&uv_q) : 16'h0;
            out_q <= fb_out_window_in ? out_q + 16'(~&out_q) : 16'h0;
            win_q <= fb_in_window_in ? win_q + 16'(~&win_q) : 16'h0;
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Shutdown causes
    property p_off;
        !turn_on_in [*5] |-> !switch_enable && discharge_on && output_ok_flag_oe;
    endproperty
    a_off: assert property (p_off) else $error("active while off");
    property p_lock;
        supply_lockout_in [*5] |-> !switch_enable && output_ok_flag_oe;
    endproperty
    a_lock: assert property (p_lock) else $error("active in lockout");
    property p_hot;
        overtemp_in [*5] |-> !switch_enable && high_side_block && low_side_block && discharge_on;
    endproperty
    a_hot: assert property (p_hot) else $error("active while hot");
    // Deglitched voltage faults, output-ok release, ramp charge order
    property p_uv;
        uv_q > 16'h2814 |-> !switch_enable;
    endproperty
    a_uv: assert property (p_uv) else $error("undervoltage not shut down");
    property p_ov;
        ov_q > 16'h050A |-> high_side_block && low_side_block && discharge_on;
    endproperty
    a_ov: assert property (p_ov) else $error("overvoltage not handled");
    property p_okf;
        out_q > 16'h050A |-> output_ok_flag_oe;
    endproperty
    a_okf: assert property (p_okf) else $error("ok not pulled low");
    property p_okr;
        $fell(output_ok_flag_oe) |-> win_q > 16'h0A00;
    endproperty
    a_okr: assert property (p_okr) else $error("ok released early");
    property p_chg;
        $rose(ramp_charge) |-> $past(ramp_cap_low_in, 2);
    endproperty
    a_chg: assert property (p_chg) else $error("charge before discharge");
    // Main scenarios reached
    c_okr: cover property ($fell(output_ok_flag_oe));
    c_ov: cover property (ov_q > 16'h050A);
    c_chg: cover property ($rose(ramp_charge));
endmodule : bpgs_seq_checker
bind bpgs_seq bpgs_seq_checker u_chk (
    .pclk, .presetn, .turn_on_in, .supply_lockout_in, .fb_in_window_in, .fb_out_window_in,
    .overvoltage_guard_in, .undervoltage_guard_in, .overtemp_in, .ramp_cap_low_in,
    .ramp_charge, .switch_enable, .high_side_block, .low_side_block, .discharge_on,
    .output_ok_flag_oe
);
`default_nettype wire

// >>> dv/bpgs_seq_tb.sv
// Self-checking bench of the supervisory sequencer
`timescale 1ns/10ps
`default_nettype none
module bpgs_seq_tb
    import bpgs_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn, ce, psel, penable, pwrite, pready, pslverr, hold_off, ok_seen, perr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic turn_on_in, supply_lockout_in, vcc_lockout_in, fb_in_window_in, fb_out_window_in;
    logic overvoltage_guard_in, undervoltage_guard_in, overcurrent_valley_in;
    logic overcurrent_peak_in, overtemp_in, ramp_cap_low_in, ref_above_fb_in, ramp_done_in;
    logic zero_current_in, high_duty_in, ramp_charge, ramp_discharge, switch_enable;
    logic high_side_block, low_side_block, rectifier_off, freq_reduce, discharge_on;
    logic output_ok_flag_o, output_ok_flag_oe;
    int n_mismatch = 0;
    int n_tests = 0;
    // 40 MHz clock
    always #12.5 pclk = ~pclk;
    bpgs_seq uut (.*);
    bpgs_host_model host (
        .output_ok_flag_o, .output_ok_flag_oe, .hold_off, .ok_seen, .turn_on_line(turn_on_in)
    );
    // Shared helpers
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        perr = pslverr;
        if (k == 20) begin
            chk("pready", 1'h0, 1'h1);
            test_done();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic st(input logic [2:0] e);
        apb(1'b0, STAT_OFS, 32'h0);
        chk("state", rd[2:0], e);
    endtask : st
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done
    // Register map, refusal of an unmapped word, short hiccup base
    task automatic t_regs();
        apb(1'b0, CTRL_OFS, 32'h0);
        chk("ctrl", rd, 32'h2);
        apb(1'b1, 8'h0C, 32'h5);
        chk("unmapped err", perr, 1'h1);
        apb(1'b1, SSLEN_OFS, 32'h14);
        apb(1'b0, SSLEN_OFS, 32'h0);
        chk("sslen", rd, 32'h14);
        $display("regs done");
    endtask : t_regs
    // Soft start walk up to a released output-ok
    task automatic t_start();
        hold_off <= 1'b0;
        cyc(8);
        chk("ramp dis", ramp_discharge, 1'h1);
        ramp_cap_low_in <= 1'b1;
        cyc(8);
        chk("ramp chg", ramp_charge, 1'h1);
        chk("sw held", switch_enable, 1'h0);
        ref_above_fb_in <= 1'b1;
        ramp_done_in <= 1'b1;
        cyc(8);
        st(3'h4);
        fb_in_window_in <= 1'b1;
        cyc(2500);
        chk("ok early", ok_seen, 1'h0);
        cyc(100);
        chk("ok up", ok_seen, 1'h1);
        $display("start done");
    endtask : t_start
    // Overvoltage deglitch and non-latched return
    task automatic t_ov();
        overvoltage_guard_in <= 1'b1;
        cyc(1200);
        chk("ov early", high_side_block, 1'h0);
        cyc(100);
        chk("ov dis", discharge_on, 1'h1);
        chk("ov ls", low_side_block, 1'h1);
        overvoltage_guard_in <= 1'b0;
        cyc(8);
        st(3'h4);
        $display("ov done");
    endtask : t_ov
    // Undervoltage wait, output-ok fall, hiccup length
    task automatic t_uv();
        cyc(2600);
        chk("ok back", ok_seen, 1'h1);
        {undervoltage_guard_in, fb_out_window_in, fb_in_window_in} <= 3'h6;
        cyc(1200);
        chk("ok fall early", ok_seen, 1'h1);
        cyc(100);
        chk("ok low", ok_seen, 1'h0);
        cyc(8900);
        chk("uv wait", switch_enable, 1'h1);
        cyc(100);
        {undervoltage_guard_in, fb_out_window_in, fb_in_window_in, ramp_cap_low_in} <= 4'h2;
        st(3'h6);
        chk("hic dis", discharge_on, 1'h1);
        cyc(100);
        st(3'h6);
        cyc(100);
        st(3'h1);
        ramp_cap_low_in <= 1'b1;
        $display("uv done");
    endtask : t_uv
    // Turn-on, supply, regulator and thermal shutdowns
    task automatic t_shut();
        cyc(2600);
        chk("ok on", ok_seen, 1'h1);
        hold_off <= 1'b1;
        cyc(8);
        chk("off ok", ok_seen, 1'h0);
        hold_off <= 1'b0;
        cyc(20);
        st(3'h4);
        supply_lockout_in <= 1'b1;
        cyc(8);
        chk("lock sw", switch_enable, 1'h0);
        supply_lockout_in <= 1'b0;
        vcc_lockout_in <= 1'b1;
        cyc(8);
        chk("vcc sw", switch_enable, 1'h0);
        {vcc_lockout_in, overtemp_in, ramp_done_in} <= 3'h2;
        cyc(20);
        chk("hot sw", switch_enable, 1'h0);
        chk("hot dis", discharge_on, 1'h1);
        overtemp_in <= 1'b0;
        cyc(20);
        st(3'h3);
        ramp_done_in <= 1'b1;
        cyc(8);
        st(3'h4);
        $display("shutdown done");
    endtask : t_shut
    // Light-load variants, high duty, current limit recovery
    task automatic t_mode();
        {zero_current_in, high_duty_in, overcurrent_peak_in, overcurrent_valley_in} <= 4'hF;
        cyc(8);
        chk("rect off", rectifier_off, 1'h1);
        chk("freq", freq_reduce, 1'h1);
        chk("peak blk", high_side_block, 1'h1);
        chk("valley blk", low_side_block, 1'h1);
        {overcurrent_peak_in, overcurrent_valley_in} <= 2'h0;
        apb(1'b1, CTRL_OFS, 32'h3);
        cyc(8);
        chk("forced mode", rectifier_off, 1'h0);
        chk("blk clear", high_side_block, 1'h0);
        st(3'h4);
        apb(1'b1, CTRL_OFS, 32'h1);
        cyc(4);
        st(3'h0);
        $display("modes done");
    endtask : t_mode
    // Reset, then the scenarios in order
    initial begin
        {presetn, ce, psel, penable, pwrite, hold_off, paddr, pwdata} = {6'h13, 40'h0};
        {supply_lockout_in, vcc_lockout_in, fb_in_window_in, fb_out_window_in} = 4'h0;
        {overvoltage_guard_in, undervoltage_guard_in, overcurrent_valley_in} = 3'h0;
        {overcurrent_peak_in, overtemp_in, ramp_cap_low_in, ref_above_fb_in} = 4'h0;
        {ramp_done_in, zero_current_in, high_duty_in} = 3'h0;
        cyc(20);
        presetn <= 1'b1;
        cyc(1);
        t_regs();
        t_start();
        t_ov();
        t_uv();
        t_shut();
        t_mode();
        test_done();
    end
endmodule : bpgs_seq_tb
`default_nettype wire
